// *** rtl/smm_pkg.sv ***
/*
 Shared constants, types and helpers for the two-wire monitor port and its host.
 Assumes one 10 MHz clock at both ends and pins that idle high.
*/
package smm_pkg;

  localparam logic [6:0] ARA_ADDR  = 7'h0C;
  localparam logic [7:0] REG_CFG   = 8'h40;
  localparam logic [7:0] REG_STAT  = 8'h41;
  localparam logic [7:0] REG_MASK  = 8'h43;
  localparam logic [7:0] REG_SADDR = 8'h48;
  localparam logic [7:0] REG_TMODE = 8'h4B;

  localparam logic [7:0] CFG_RST   = 8'h00;
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic [7:0] TMODE_RST = 8'h00;
  localparam logic [4:0] STAT_RST  = 5'h00;
  localparam logic [7:0] PTR_RST   = 8'h00;

  localparam int CFG_RUN   = 0;
  localparam int CFG_AEN   = 1;
  localparam int CFG_ACLR  = 3;
  localparam int CFG_LINE  = 4;
  localparam int CFG_OSR   = 5;
  localparam int CFG_SRST  = 7;
  localparam int STAT_TEMP = 4;

  localparam logic [1:0] STRAP_GND = 2'd0;
  localparam logic [1:0] STRAP_SDA = 2'd1;
  localparam logic [1:0] STRAP_SCL = 2'd2;
  localparam logic [1:0] STRAP_VCC = 2'd3;
  localparam logic [6:0] ADDR_BASE = 7'h14;

  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    TM_DEFAULT = 2'b00,
    TM_ONCE    = 2'b01,
    TM_COMPAR  = 2'b10
  } smm_tmode_t;

  typedef enum logic [1:0] {
    K_WRITE = 2'b00,
    K_READ  = 2'b01,
    K_SEND  = 2'b10,
    K_RECV  = 2'b11
  } smm_kind_t;

  // Strap code selects one of four consecutive addresses
  function automatic logic [6:0] strap_addr(input logic [1:0] s);
    strap_addr = ADDR_BASE + {5'd0, s};
  endfunction

  function automatic smm_tmode_t tmode_decode(input logic [1:0] f);
    unique case (f)
      2'b01:   tmode_decode = TM_ONCE;
      2'b10:   tmode_decode = TM_COMPAR;
      default: tmode_decode = TM_DEFAULT;
    endcase
  endfunction

endpackage

// *** rtl/smm_if.sv ***
/*
 Two-wire bus, alert line and address strap joining host and monitor.
 Assumes open-drain pins with pull-ups; STRAP tells where the strap pin is tied.
*/
interface smm_if #(
  parameter logic [1:0] STRAP = smm_pkg::STRAP_GND
);
  logic scl_oe_h;
  logic sda_oe_h;
  logic sda_oe_d;
  logic alert_oe;
  logic scl;
  logic sda;
  logic alert_n;
  logic add;

  assign scl     = ~scl_oe_h;
  assign sda     = ~(sda_oe_h | sda_oe_d);
  assign alert_n = ~alert_oe;

  always_comb begin
    unique case (STRAP)
      smm_pkg::STRAP_GND: add = 1'b0;
      smm_pkg::STRAP_SDA: add = sda;
      smm_pkg::STRAP_SCL: add = scl;
      default:            add = 1'b1;
    endcase
  end

  modport dev (input scl, input sda, input add, output sda_oe_d, output alert_oe);
  modport host (input scl, input sda, input alert_n, output scl_oe_h, output sda_oe_h);
endinterface

// *** rtl/smm_dev.sv ***
/*
 Monitor end: two-wire slave with command pointer, configuration, temperature
 mode, mask, status and serial address registers; other registers sit outside.
 Assumes the outside register file answers ext_rdata for reg_ptr_q at all times.
*/
module smm_dev (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Bus pins
  smm_if.dev                      bus,
  // Fault events from the comparators
  input  wire logic [4:0]         fault_evt,
  input  wire logic               temp_hot,
  // Outside register file
  input  wire logic [7:0]         ext_rdata,
  output logic      [7:0]         reg_ptr_q,
  output logic      [7:0]         ext_wdata_q,
  output logic                    ext_we_q,
  output logic                    ext_re_q,
  // Monitor control
  output logic                    conv_run_q,
  output logic                    line50_q,
  output logic                    osr2_q,
  output smm_pkg::smm_tmode_t     temp_mode_q,
  output logic                    soft_rst_q
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RX    = 3'b001,
    ST_ACK   = 3'b010,
    ST_TX    = 3'b011,
    ST_TXACK = 3'b100
  } smm_state_t;

  typedef enum logic [1:0] {
    B_ADDR = 2'b00,
    B_CMD  = 2'b01,
    B_DATA = 2'b10
  } smm_byte_t;

  logic       scl_m, scl_s, scl_p;
  logic       sda_m, sda_s, sda_p;
  logic       add_m, add_s, add_p;
  logic       start, stop, rise, fall;
  logic [1:0] strap_q;
  logic       strap_pend_q;
  logic [6:0] my_addr;
  smm_state_t state_q;
  smm_byte_t  byte_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic       ack_q, ackph_q, rw_q, ara_q, sda_oe_q;
  logic [7:0] rx_byte, tx_byte;
  logic       byte_done, cmd_done, wr_en, srst_wr, tx_load, stat_rd, is_comp;
  logic       ext_sel, addr_hit;
  logic [7:0] cfg_q, tmode_q, mask_q, saddr_q;
  logic       saddr_v_q;
  logic [4:0] stat_q, stat_d;
  logic       alert_oe_q;

  // Pin synchronisers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {scl_m, scl_s, scl_p} <= 3'b111;
      {sda_m, sda_s, sda_p} <= 3'b111;
      {add_m, add_s, add_p} <= 3'b000;
    end else begin
      scl_m <= bus.scl;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= bus.sda;
      sda_s <= sda_m;
      sda_p <= sda_s;
      add_m <= bus.add;
      add_s <= add_m;
      add_p <= add_s;
    end
  end

  assign start = scl_s & scl_p & sda_p & ~sda_s;
  assign stop  = scl_s & scl_p & ~sda_p & sda_s;
  assign rise  = scl_s & ~scl_p;
  assign fall  = ~scl_s & scl_p;

  // Strap follows SDA if it falls with start, SCL if it falls with SCL
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strap_q      <= smm_pkg::STRAP_GND;
      strap_pend_q <= 1'b0;
    end else if (start) begin
      strap_q      <= add_p ? (add_s ? smm_pkg::STRAP_VCC : smm_pkg::STRAP_SDA)
                            : smm_pkg::STRAP_GND;
      strap_pend_q <= add_p & add_s;
    end else if (strap_pend_q && fall) begin
      strap_q      <= add_s ? smm_pkg::STRAP_VCC : smm_pkg::STRAP_SCL;
      strap_pend_q <= 1'b0;
    end
  end

  assign my_addr = saddr_v_q ? saddr_q[6:0] : smm_pkg::strap_addr(strap_q);

  assign rx_byte   = {sh_q[6:0], sda_s};
  assign byte_done = (state_q == ST_RX) && rise && (cnt_q == 3'd7);
  assign cmd_done  = byte_done && (byte_q == B_CMD);
  assign wr_en     = byte_done && (byte_q == B_DATA);
  assign srst_wr   = wr_en && (reg_ptr_q == smm_pkg::REG_CFG) && rx_byte[smm_pkg::CFG_SRST];
  assign addr_hit  = (rx_byte[7:1] == my_addr)
                  || (rx_byte[7:1] == smm_pkg::ARA_ADDR && rx_byte[0] && alert_oe_q);
  assign tx_load   = (state_q == ST_ACK && fall && ackph_q && ack_q && rw_q && byte_q == B_ADDR)
                  || (state_q == ST_TXACK && rise && !sda_s);
  assign stat_rd   = tx_load && !ara_q && (reg_ptr_q == smm_pkg::REG_STAT);
  assign is_comp   = smm_pkg::tmode_decode(tmode_q[1:0]) == smm_pkg::TM_COMPAR;
  assign ext_sel   = reg_ptr_q != smm_pkg::REG_CFG && reg_ptr_q != smm_pkg::REG_STAT
                  && reg_ptr_q != smm_pkg::REG_MASK && reg_ptr_q != smm_pkg::REG_SADDR
                  && reg_ptr_q != smm_pkg::REG_TMODE;

  // Byte returned to the host
  always_comb begin
    if (ara_q) begin
      tx_byte = {my_addr, 1'b0};
    end else begin
      unique case (1'b1)
        reg_ptr_q == smm_pkg::REG_CFG:   tx_byte = cfg_q;
        reg_ptr_q == smm_pkg::REG_STAT:  tx_byte = {3'b000, stat_q};
        reg_ptr_q == smm_pkg::REG_MASK:  tx_byte = mask_q;
        reg_ptr_q == smm_pkg::REG_SADDR: tx_byte = {1'b0, my_addr};
        reg_ptr_q == smm_pkg::REG_TMODE: tx_byte = tmode_q;
        default:                         tx_byte = ext_rdata;
      endcase
    end
  end

  // Bus sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q  <= ST_IDLE;
      byte_q   <= B_ADDR;
      cnt_q    <= 3'd0;
      sh_q     <= 8'h00;
      ack_q    <= 1'b0;
      ackph_q  <= 1'b0;
      rw_q     <= 1'b0;
      ara_q    <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start) begin
      state_q  <= ST_RX;
      byte_q   <= B_ADDR;
      cnt_q    <= 3'd0;
      ara_q    <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (stop) begin
      state_q  <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_RX: begin
          if (rise) begin
            sh_q  <= rx_byte;
            cnt_q <= cnt_q + 3'd1;
            if (cnt_q == 3'd7) begin
              state_q <= ST_ACK;
              ackph_q <= 1'b0;
              if (byte_q == B_ADDR) begin
                ack_q <= addr_hit;
                rw_q  <= rx_byte[0];
                ara_q <= rx_byte[7:1] == smm_pkg::ARA_ADDR;
              end else begin
                ack_q <= 1'b1;
              end
            end
          end
        end
        ST_ACK: begin
          if (fall) begin
            if (!ackph_q) begin
              sda_oe_q <= ack_q;
              ackph_q  <= 1'b1;
            end else if (!ack_q) begin
              sda_oe_q <= 1'b0;
              state_q  <= ST_IDLE;
            end else if (rw_q && byte_q == B_ADDR) begin
              sh_q     <= tx_byte;
              sda_oe_q <= ~tx_byte[7];
              cnt_q    <= 3'd0;
              state_q  <= ST_TX;
            end else begin
              sda_oe_q <= 1'b0;
              cnt_q    <= 3'd0;
              state_q  <= ST_RX;
              byte_q   <= (byte_q == B_ADDR) ? B_CMD : B_DATA;
            end
          end
        end
        ST_TX: begin
          if (rise) begin
            if (!sda_oe_q && !sda_s) begin
              state_q <= ST_IDLE;
            end else begin
              sh_q  <= {sh_q[6:0], 1'b0};
              cnt_q <= cnt_q + 3'd1;
              if (cnt_q == 3'd7) begin
                state_q <= ST_TXACK;
              end
            end
          end else if (fall) begin
            sda_oe_q <= ~sh_q[7];
          end
        end
        ST_TXACK: begin
          if (fall) begin
            sda_oe_q <= 1'b0;
          end else if (rise) begin
            if (sda_s) begin
              state_q <= ST_IDLE;
            end else begin
              sh_q    <= tx_byte;
              cnt_q   <= 3'd0;
              state_q <= ST_TX;
            end
          end
        end
        ST_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        default: begin
          state_q  <= ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Command pointer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_ptr_q <= smm_pkg::PTR_RST;
    end else if (cmd_done) begin
      reg_ptr_q <= rx_byte;
    end
  end

  // Local registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_q     <= smm_pkg::CFG_RST;
      tmode_q   <= smm_pkg::TMODE_RST;
      mask_q    <= smm_pkg::MASK_RST;
      saddr_q   <= 8'h00;
      saddr_v_q <= 1'b0;
    end else if (srst_wr) begin
      cfg_q   <= smm_pkg::CFG_RST;
      tmode_q <= smm_pkg::TMODE_RST;
      mask_q  <= smm_pkg::MASK_RST;
    end else if (wr_en) begin
      unique case (1'b1)
        reg_ptr_q == smm_pkg::REG_CFG:   cfg_q   <= rx_byte;
        reg_ptr_q == smm_pkg::REG_TMODE: tmode_q <= rx_byte;
        reg_ptr_q == smm_pkg::REG_MASK:  mask_q  <= rx_byte;
        reg_ptr_q == smm_pkg::REG_SADDR: begin
          saddr_q   <= rx_byte;
          saddr_v_q <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // Status: new faults win over a read clear
  always_comb begin
    stat_d = stat_q;
    if (stat_rd) begin
      stat_d = is_comp ? {stat_q[4], 4'h0} : smm_pkg::STAT_RST;
    end
    stat_d = stat_d | (fault_evt & ~mask_q[4:0]);
    if (is_comp) begin
      stat_d[smm_pkg::STAT_TEMP] = temp_hot & ~mask_q[smm_pkg::STAT_TEMP];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_q <= smm_pkg::STAT_RST;
    end else if (srst_wr) begin
      stat_q <= smm_pkg::STAT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Alert line; an alert response leaves it alone
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alert_oe_q <= 1'b0;
    end else begin
      alert_oe_q <= cfg_q[smm_pkg::CFG_AEN] & ~cfg_q[smm_pkg::CFG_ACLR]
                  & |(stat_q & ~mask_q[4:0]);
    end
  end

  assign bus.alert_oe = alert_oe_q;
  assign bus.sda_oe_d = sda_oe_q;

  // Monitor control and outside register strobes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conv_run_q  <= 1'b0;
      line50_q    <= 1'b0;
      osr2_q      <= 1'b0;
      temp_mode_q <= smm_pkg::TM_DEFAULT;
      soft_rst_q  <= 1'b0;
      ext_we_q    <= 1'b0;
      ext_re_q    <= 1'b0;
      ext_wdata_q <= 8'h00;
    end else begin
      conv_run_q  <= cfg_q[smm_pkg::CFG_RUN] & ~cfg_q[smm_pkg::CFG_ACLR];
      line50_q    <= cfg_q[smm_pkg::CFG_LINE];
      osr2_q      <= cfg_q[smm_pkg::CFG_OSR];
      temp_mode_q <= smm_pkg::tmode_decode(tmode_q[1:0]);
      soft_rst_q  <= srst_wr;
      ext_we_q    <= wr_en && ext_sel;
      ext_re_q    <= tx_load && !ara_q && ext_sel;
      if (wr_en) begin
        ext_wdata_q <= rx_byte;
      end
    end
  end

endmodule

// *** rtl/smm_host.sv ***
/*
 Host end: issues one write, read, send or receive byte per command.
 Assumes the monitor never stretches SCL; SCL runs at SCL_PERIOD_NS.
*/
module smm_host (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Bus pins
  smm_if.host                     bus,
  // Command
  input  wire logic               cmd_valid,
  input  wire smm_pkg::smm_kind_t cmd_kind,
  input  wire logic [6:0]         cmd_addr,
  input  wire logic [7:0]         cmd_reg,
  input  wire logic [7:0]         cmd_data,
  // Answer
  output logic                    busy_q,
  output logic                    done_q,
  output logic                    nack_q,
  output logic      [7:0]         rdata_q,
  output logic                    alert_q
);

  typedef enum logic [2:0] {
    IT_START = 3'b000,
    IT_AW    = 3'b001,
    IT_AR    = 3'b010,
    IT_CMD   = 3'b011,
    IT_DATA  = 3'b100,
    IT_RD    = 3'b101,
    IT_STOP  = 3'b110
  } smm_item_t;

  localparam logic [4:0] QTR_LAST = 5'(smm_pkg::QTR_CYC - 1);

  smm_pkg::smm_kind_t kind_q;
  smm_item_t          item_q, nxt_item;
  logic [6:0]         addr_q;
  logic [7:0]         reg_q, dat_q, sh_q;
  logic [4:0]         cnt_q;
  logic [1:0]         ph_q;
  logic [3:0]         bit_q;
  logic [2:0]         step_q;
  logic               scl_oe_q, sda_oe_q, sda_m, sda_s, alert_m, tick;

  // Transaction forms as item lists
  function automatic smm_item_t item_at(input smm_pkg::smm_kind_t k, input logic [2:0] s);
    item_at = IT_STOP;
    unique case (k)
      smm_pkg::K_WRITE: begin
        unique case (s)
          3'd0:    item_at = IT_START;
          3'd1:    item_at = IT_AW;
          3'd2:    item_at = IT_CMD;
          3'd3:    item_at = IT_DATA;
          default: item_at = IT_STOP;
        endcase
      end
      smm_pkg::K_READ: begin
        unique case (s)
          3'd0, 3'd3: item_at = IT_START;
          3'd1:       item_at = IT_AW;
          3'd2:       item_at = IT_CMD;
          3'd4:       item_at = IT_AR;
          3'd5:       item_at = IT_RD;
          default:    item_at = IT_STOP;
        endcase
      end
      smm_pkg::K_SEND: begin
        unique case (s)
          3'd0:    item_at = IT_START;
          3'd1:    item_at = IT_AW;
          3'd2:    item_at = IT_CMD;
          default: item_at = IT_STOP;
        endcase
      end
      smm_pkg::K_RECV: begin
        unique case (s)
          3'd0:    item_at = IT_START;
          3'd1:    item_at = IT_AR;
          3'd2:    item_at = IT_RD;
          default: item_at = IT_STOP;
        endcase
      end
    endcase
  endfunction

  function automatic logic [7:0] load_of(input smm_item_t it);
    unique case (it)
      IT_AW:   load_of = {addr_q, 1'b0};
      IT_AR:   load_of = {addr_q, 1'b1};
      IT_CMD:  load_of = reg_q;
      IT_DATA: load_of = dat_q;
      default: load_of = 8'hFF;
    endcase
  endfunction

  assign tick     = cnt_q == QTR_LAST;
  assign nxt_item = nack_q ? IT_STOP : item_at(kind_q, step_q + 3'd1);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sda_m   <= 1'b1;
      sda_s   <= 1'b1;
      alert_m <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      sda_m   <= bus.sda;
      sda_s   <= sda_m;
      alert_m <= ~bus.alert_n;
      alert_q <= alert_m;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 5'd0;
    end else if (!busy_q || tick) begin
      cnt_q <= 5'd0;
    end else begin
      cnt_q <= cnt_q + 5'd1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      nack_q   <= 1'b0;
      rdata_q  <= 8'h00;
      kind_q   <= smm_pkg::K_WRITE;
      item_q   <= IT_START;
      addr_q   <= 7'h00;
      reg_q    <= 8'h00;
      dat_q    <= 8'h00;
      sh_q     <= 8'h00;
      ph_q     <= 2'd0;
      bit_q    <= 4'd0;
      step_q   <= 3'd0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q) begin
        if (cmd_valid) begin
          busy_q <= 1'b1;
          nack_q <= 1'b0;
          kind_q <= cmd_kind;
          addr_q <= cmd_addr;
          reg_q  <= cmd_reg;
          dat_q  <= cmd_data;
          item_q <= IT_START;
          step_q <= 3'd0;
          ph_q   <= 2'd0;
        end
      end else if (tick) begin
        ph_q <= ph_q + 2'd1;
        unique case (item_q)
          IT_START: begin
            unique case (ph_q)
              2'd0: sda_oe_q <= 1'b0;
              2'd1: scl_oe_q <= 1'b0;
              2'd2: sda_oe_q <= 1'b1;
              2'd3: begin
                scl_oe_q <= 1'b1;
                step_q   <= step_q + 3'd1;
                item_q   <= nxt_item;
                sh_q     <= load_of(nxt_item);
                bit_q    <= 4'd0;
              end
            endcase
          end
          IT_STOP: begin
            unique case (ph_q)
              2'd0: sda_oe_q <= 1'b1;
              2'd1: scl_oe_q <= 1'b0;
              2'd2: sda_oe_q <= 1'b0;
              2'd3: begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end
            endcase
          end
          default: begin
            unique case (ph_q)
              2'd0: sda_oe_q <= (bit_q < 4'd8) && (item_q != IT_RD) && !sh_q[7];
              2'd1: scl_oe_q <= 1'b0;
              2'd2: begin
                if (bit_q < 4'd8) begin
                  sh_q <= {sh_q[6:0], sda_s};
                end else if (item_q != IT_RD && sda_s) begin
                  nack_q <= 1'b1;
                end
              end
              2'd3: begin
                scl_oe_q <= 1'b1;
                bit_q    <= bit_q + 4'd1;
                if (bit_q == 4'd8) begin
                  if (item_q == IT_RD) begin
                    rdata_q <= sh_q;
                  end
                  step_q <= step_q + 3'd1;
                  item_q <= nxt_item;
                  sh_q   <= load_of(nxt_item);
                  bit_q  <= 4'd0;
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  assign bus.scl_oe_h = scl_oe_q;
  assign bus.sda_oe_h = sda_oe_q;

endmodule

// *** sim/smm_properties.sv ***
/*
 Link checker between host and monitor ends.
 Assumes one clock domain and the interface's wire levels.
*/
module smm_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link
  input wire logic sda_oe_d,
  input wire logic alert_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  chk_dev_hold_high: assert property (
    $rose(scl) |-> $stable(sda_oe_d) [*8]) else $error("device moved SDA with SCL high");
  chk_dev_drive_late: assert property (
    $rose(sda_oe_d) |-> !scl && !$past(scl) && $past(scl, 10)) else $error("device drive early");
  chk_dev_release_fall: assert property (
    $fell(sda_oe_d) |-> !scl && !$past(scl) && $past(scl, 10)) else $error("device release off");
  chk_drive_bounded: assert property (
    $rose(sda_oe_d) |-> ##[1:1000] !sda_oe_d) else $error("device holds SDA too long");
  chk_scl_low_min: assert property (
    $fell(scl) |-> !scl [*8]) else $error("SCL low phase short");
  chk_scl_high_min: assert property (
    $rose(scl) |-> scl [*8]) else $error("SCL high phase short");
  chk_start_stop_host: assert property (
    $changed(sda) && scl && $past(scl) |-> !sda_oe_d && !$past(sda_oe_d))
    else $error("device made start or stop");
  chk_reset_quiet: assert property (
    $fell(rst) |-> !sda_oe_d && !alert_oe ##1 !sda_oe_d) else $error("device busy after reset");

  cover property ($rose(sda_oe_d));
  cover property ($rose(alert_oe));
  cover property ($fell(alert_oe));
endmodule

// *** sim/tb_top.sv ***
/*
 Bench: host and monitor joined by the interface, scenarios in tasks.
 Assumes the package constants and a 10 MHz clock.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] DA = smm_pkg::ADDR_BASE + 7'h02;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic temp_hot = 1'b0;
  smm_pkg::smm_kind_t cmd_kind = smm_pkg::K_WRITE;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic [4:0] fault_evt = 5'h00;
  logic [7:0] ext_rdata = 8'h00;
  logic [7:0] reg_ptr_q, ext_wdata_q, rdata_q;
  logic ext_we_q, ext_re_q, busy_q, conv_run_q, line50_q, osr2_q;
  logic soft_rst_q, done_q, nack_q, alert_q;
  smm_pkg::smm_tmode_t temp_mode_q;
  int we_n = 0;
  int sr_n = 0;
  int re_n = 0;
  int fail_count = 0;
  int comparisons = 0;

  smm_if #(.STRAP(smm_pkg::STRAP_SCL)) bus ();
  smm_dev i_smm_dev (.ref_clk, .rst, .bus(bus), .fault_evt, .temp_hot, .ext_rdata,
    .reg_ptr_q, .ext_wdata_q, .ext_we_q, .ext_re_q, .conv_run_q, .line50_q, .osr2_q,
    .temp_mode_q, .soft_rst_q);
  smm_host i_smm_host (.ref_clk, .rst, .bus(bus), .cmd_valid, .cmd_kind, .cmd_addr,
    .cmd_reg, .cmd_data, .busy_q, .done_q, .nack_q, .rdata_q, .alert_q);
  smm_properties i_smm_properties (.ref_clk, .rst, .sda_oe_d(bus.sda_oe_d),
    .alert_oe(bus.alert_oe), .scl(bus.scl), .sda(bus.sda));

  always #50 ref_clk = ~ref_clk;

  // Outside register file answers a scrambled pointer
  always @(posedge ref_clk) begin
    ext_rdata <= reg_ptr_q ^ 8'h5A;
    we_n <= we_n + int'(ext_we_q);
    sr_n <= sr_n + int'(soft_rst_q);
    re_n <= re_n + int'(ext_re_q);
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xfer(input smm_pkg::smm_kind_t k, input logic [6:0] a,
                      input logic [7:0] r, input logic [7:0] d);
    int n = 0;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_reg <= r;
    cmd_data <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    while (done_q !== 1'b1 && n < 9000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 9000) chk(8'h00, 8'h01, "done");
    chk({7'h00, busy_q}, 8'h00, "busy");
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    xfer(smm_pkg::K_WRITE, DA, r, d);
  endtask

  task automatic rd(input logic [7:0] r);
    xfer(smm_pkg::K_READ, DA, r, 8'h00);
  endtask

  task automatic fault();
    @(posedge ref_clk);
    fault_evt <= 5'h01;
    @(posedge ref_clk);
    fault_evt <= 5'h00;
    repeat (6) @(negedge ref_clk);
  endtask

  task automatic t_data();
    rd(smm_pkg::REG_CFG);
    chk(rdata_q, smm_pkg::CFG_RST, "cfg reset");
    wr(8'h10, 8'hC3);
    chk(ext_wdata_q, 8'hC3, "wdata");
    chk(reg_ptr_q, 8'h10, "pointer");
    chk(8'(we_n), 8'h01, "write pulses");
    rd(8'h10);
    chk(rdata_q, 8'h4A, "read data");
    chk(8'(re_n), 8'h01, "read pulses");
    chk({7'h00, nack_q}, 8'h00, "read ack");
  endtask

  task automatic t_cfg();
    wr(smm_pkg::REG_CFG, 8'h31);
    chk({5'h00, conv_run_q, line50_q, osr2_q}, 8'h07, "run modes");
    wr(smm_pkg::REG_CFG, 8'h38);
    chk({7'h00, conv_run_q}, 8'h00, "halt");
    for (int i = 0; i < 4; i++) begin
      wr(smm_pkg::REG_TMODE, 8'(i));
      chk({6'h00, temp_mode_q}, (i == 3) ? 8'h00 : 8'(i), "temp mode");
    end
  endtask

  task automatic t_ptr();
    xfer(smm_pkg::K_SEND, DA, 8'h10, 8'h00);
    chk(reg_ptr_q, 8'h10, "send pointer");
    chk(8'(we_n), 8'h01, "send no write");
    xfer(smm_pkg::K_RECV, DA, 8'h00, 8'h00);
    chk(rdata_q, 8'h4A, "receive ext");
    xfer(smm_pkg::K_SEND, DA, smm_pkg::REG_TMODE, 8'h00);
    xfer(smm_pkg::K_RECV, DA, 8'h00, 8'h00);
    chk(rdata_q, 8'h03, "receive mode");
  endtask

  task automatic t_alert();
    wr(smm_pkg::REG_CFG, 8'h02);
    fault();
    chk({7'h00, alert_q}, 8'h01, "alert on");
    xfer(smm_pkg::K_RECV, smm_pkg::ARA_ADDR, 8'h00, 8'h00);
    chk(rdata_q, {DA, 1'b0}, "alert answer");
    chk({7'h00, alert_q}, 8'h01, "alert kept");
    wr(smm_pkg::REG_MASK, 8'h01);
    chk({7'h00, alert_q}, 8'h00, "alert masked");
    wr(smm_pkg::REG_MASK, 8'h00);
    rd(smm_pkg::REG_STAT);
    chk(rdata_q, 8'h01, "status");
    chk({7'h00, alert_q}, 8'h00, "status cleared");
    wr(smm_pkg::REG_CFG, 8'h80);
    chk(8'(sr_n), 8'h01, "soft reset");
    fault();
    chk({7'h00, alert_q}, 8'h00, "alert disabled");
    rd(smm_pkg::REG_CFG);
    chk(rdata_q, smm_pkg::CFG_RST, "cfg restored");
    wr(smm_pkg::REG_TMODE, 8'h02);
    @(posedge ref_clk);
    temp_hot <= 1'b1;
    rd(smm_pkg::REG_STAT);
    chk(rdata_q, 8'h11, "comparator status");
    xfer(smm_pkg::K_RECV, DA, 8'h00, 8'h00);
    chk(rdata_q, 8'h10, "comparator kept");
  endtask

  task automatic t_addr();
    xfer(smm_pkg::K_READ, DA ^ 7'h01, smm_pkg::REG_CFG, 8'h00);
    chk({7'h00, nack_q}, 8'h01, "other address");
    wr(smm_pkg::REG_SADDR, 8'h21);
    xfer(smm_pkg::K_READ, 7'h21, smm_pkg::REG_SADDR, 8'h00);
    chk({nack_q, rdata_q[6:0]}, 8'h21, "new address");
    rd(smm_pkg::REG_CFG);
    chk({7'h00, nack_q}, 8'h01, "strap overridden");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_data();
    t_cfg();
    t_ptr();
    t_alert();
    t_addr();
    tally_and_finish();
  end

  // Cut a hang short
  initial begin
    #10_000_000;
    fail_count++;
    tally_and_finish();
  end
endmodule
